// ==== core/pbs_pkg.sv ====
// Shared types and constants of the pipelined burst SRAM
package pbs_pkg;

	localparam int ADDR_W     = 17;
	localparam int DATA_W     = 36;
	localparam int LANES      = 4;
	localparam int LANE_W     = 9;
	localparam int BEAT_W     = 2;
	localparam int WORDS      = 131072;
	localparam int FIFO_DEPTH = 4;

	typedef logic [ADDR_W-1:0] pbs_addr_t;
	typedef logic [DATA_W-1:0] pbs_data_t;
	typedef logic [LANES-1:0]  pbs_lane_t;
	typedef logic [BEAT_W-1:0] pbs_beat_t;

	localparam pbs_addr_t ADDR_RST = 17'h0_0000;
	localparam pbs_data_t DATA_RST = 36'h0_0000_0000;
	localparam pbs_beat_t BEAT_RST = 2'h0;
	localparam pbs_beat_t BEAT_ONE = 2'h1;
	localparam pbs_beat_t BEAT_TOP = 2'h3;
	localparam pbs_lane_t LANE_OFF = 4'hF;

	// Burst direction latched at the load cycle
	typedef enum logic [1:0] {
		BST_IDLE  = 2'b00,
		BST_READ  = 2'b01,
		BST_WRITE = 2'b11
	} pbs_burst_e;

	// One access travelling down the pipeline
	typedef struct packed {
		logic      valid;
		logic      write;
		pbs_addr_t addr;
		pbs_lane_t laneN;
	} pbs_cmd_s;

	// One write waiting for the memory port
	typedef struct packed {
		pbs_addr_t addr;
		pbs_lane_t laneN;
		pbs_data_t data;
	} pbs_wr_s;

	localparam pbs_cmd_s CMD_RST = '{valid: 1'b0, write: 1'b0, addr: ADDR_RST, laneN: LANE_OFF};

endpackage

// ==== core/pbs_fifo.sv ====
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ns
module pbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk,     // Clock
	input  wire logic             rst_n,    // Sync reset, active low
	input  wire logic             inValid,  // Fill side valid
	output logic                  inReady,  // Not full
	input  wire logic [WIDTH-1:0] inData,   // Fill side data
	output logic                  outValid, // Not empty
	input  wire logic             outReady, // Drain side ready
	output logic [WIDTH-1:0]      outData   // Head entry
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] slotQ [DEPTH];
	logic [PTR_W-1:0] wrPtrQ;
	logic [PTR_W-1:0] rdPtrQ;
	logic [CNT_W-1:0] countQ;
	logic             push;
	logic             pop;

	assign inReady  = (countQ != FULL_CNT);
	assign outValid = (countQ != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = slotQ[rdPtrQ];

	always_ff @(posedge mclk)
	begin
		if (push)
			slotQ[wrPtrQ] <= inData;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wrPtrQ <= '0;
			rdPtrQ <= '0;
			countQ <= '0;
		end
		else
		begin
			if (push)
				wrPtrQ <= (wrPtrQ == LAST_PTR) ? '0 : wrPtrQ + 1'b1;
			if (pop)
				rdPtrQ <= (rdPtrQ == LAST_PTR) ? '0 : rdPtrQ + 1'b1;
			if (push && !pop)
				countQ <= countQ + 1'b1;
			else if (pop && !push)
				countQ <= countQ - 1'b1;
		end
	end

endmodule // pbs_fifo

// ==== core/pbs_mem.sv ====
// Single-port word store with lane writes and registered read data
`timescale 1ns/1ns
module pbs_mem (
	input  wire logic               mclk,    // Clock
	input  wire pbs_pkg::pbs_addr_t addr,    // Word address
	input  wire logic               rdEn,    // Read strobe
	input  wire logic               wrEn,    // Write strobe
	input  wire pbs_pkg::pbs_lane_t wrLaneN, // Lane write selects, low writes
	input  wire pbs_pkg::pbs_data_t wrData,  // Write word
	output pbs_pkg::pbs_data_t      rdData   // Registered read word
);
	import pbs_pkg::*;

	pbs_data_t store [WORDS];

	always_ff @(posedge mclk)
	begin
		if (rdEn)
			rdData <= store[addr];
	end

	// Unselected lanes keep their old contents; one process owns the store
	always_ff @(posedge mclk)
	begin
		if (wrEn)
		begin
			for (int i = 0; i < LANES; i++)
				if (!wrLaneN[i])
					store[addr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
		end
	end

endmodule // pbs_mem

// ==== core/pbs_sram_core.sv ====
// Pipelined burst SRAM: command pipeline, burst counter and data bus drivers
`timescale 1ns/1ns
module pbs_sram_core (
	input  wire logic               mclk,              // 250 MHz clock
	input  wire logic               rst_n,             // Sync reset, active low
	input  wire logic               clock_gate_n,      // High blocks this edge
	input  wire pbs_pkg::pbs_addr_t addr,              // Word address
	input  wire logic               readNotWrite,      // High read, low write
	input  wire logic               advance_or_load,   // High advance, low load
	input  wire logic               select_first_n,    // Enable, active low
	input  wire logic               select_second,     // Enable, active high
	input  wire logic               select_third_n,    // Enable, active low
	input  wire pbs_pkg::pbs_lane_t byte_lane_write_n, // Lane write selects
	input  wire logic               burst_order_select,// High interleaved
	input  wire logic               outEnableN,        // Output enable, active low
	input  wire pbs_pkg::pbs_data_t dataIn,            // Data bus input
	output pbs_pkg::pbs_data_t      dataOut,           // Data bus output
	output logic                    dataOe,            // Data bus drive enable
	output logic                    writeQueueReady    // Write queue has room
);
	import pbs_pkg::*;

	logic       en;
	logic       selected;
	logic       loadCycle;
	pbs_burst_e burstQ;
	pbs_addr_t  baseQ;
	pbs_beat_t  beatQ;
	pbs_beat_t  beatNext;
	pbs_beat_t  lowNext;
	pbs_cmd_s   cmdD;
	pbs_cmd_s   s1Q;
	pbs_cmd_s   s2Q;
	logic       driveQ;
	pbs_data_t  dataOutQ;
	pbs_data_t  memRdata;
	logic       memRdEn;
	logic       memWrEn;
	pbs_addr_t  memAddr;
	logic       wrPushValid;
	pbs_wr_s    wrPush;
	logic       wrOutValid;
	pbs_wr_s    wrOut;

	assign en        = !clock_gate_n;
	assign selected  = !select_first_n && !select_third_n && select_second;
	assign loadCycle = !advance_or_load;
	assign beatNext  = beatQ + BEAT_ONE;

	// Burst address order from the latched start bits
	always_comb
	begin
		if (burst_order_select)
			lowNext = baseQ[BEAT_W-1:0] ^ beatNext;
		else
			lowNext = baseQ[BEAT_W-1:0] + beatNext;
	end

	// Burst state: direction and counter
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			burstQ <= BST_IDLE;
			baseQ  <= ADDR_RST;
			beatQ  <= BEAT_RST;
		end
		else if (en)
		begin
			if (loadCycle)
			begin
				baseQ <= addr;
				beatQ <= BEAT_RST;
				if (!selected)
					burstQ <= BST_IDLE;
				else if (readNotWrite)
					burstQ <= BST_READ;
				else
					burstQ <= BST_WRITE;
			end
			else
				beatQ <= beatNext;
		end
	end

	// Command for this enabled edge
	always_comb
	begin
		cmdD = CMD_RST;
		if (loadCycle)
		begin
			cmdD.valid = selected;
			cmdD.write = !readNotWrite;
			cmdD.addr  = addr;
			cmdD.laneN = byte_lane_write_n;
		end
		else
		begin
			cmdD.addr  = {baseQ[ADDR_W-1:BEAT_W], lowNext};
			cmdD.laneN = byte_lane_write_n;
			case (burstQ)
				BST_READ:
				begin
					cmdD.valid = 1'b1;
					cmdD.write = 1'b0;
				end
				BST_WRITE:
				begin
					cmdD.valid = 1'b1;
					cmdD.write = 1'b1;
				end
				default:
				begin
					cmdD.valid = 1'b0;
					cmdD.write = 1'b0;
				end
			endcase
		end
	end

	// Two enabled-edge pipeline; deselects only insert empty slots
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s1Q <= CMD_RST;
			s2Q <= CMD_RST;
		end
		else if (en)
		begin
			s1Q <= cmdD;
			s2Q <= s1Q;
		end
	end

	// Read data out two enabled edges after the load
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			driveQ   <= 1'b0;
			dataOutQ <= DATA_RST;
		end
		else if (en)
		begin
			driveQ <= s2Q.valid && !s2Q.write;
			if (s2Q.valid && !s2Q.write)
				dataOutQ <= memRdata;
		end
	end

	assign dataOut = dataOutQ;
	assign dataOe  = driveQ && !outEnableN;

	// Write word is taken when its access leaves the second stage
	assign wrPushValid  = en && s2Q.valid && s2Q.write;
	assign wrPush.addr  = s2Q.addr;
	assign wrPush.laneN = s2Q.laneN;
	assign wrPush.data  = dataIn;

	// Reads own the memory port; queued writes wait for a free slot
	assign memRdEn = en && s1Q.valid && !s1Q.write;
	assign memWrEn = wrOutValid && !memRdEn;
	assign memAddr = memRdEn ? s1Q.addr : wrOut.addr;

	pbs_fifo #(
		.WIDTH ($bits(pbs_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) uWrQueue (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inValid  (wrPushValid),
		.inReady  (writeQueueReady),
		.inData   (wrPush),
		.outValid (wrOutValid),
		.outReady (!memRdEn),
		.outData  (wrOut)
	);

	pbs_mem uStore (
		.mclk    (mclk),
		.addr    (memAddr),
		.rdEn    (memRdEn),
		.wrEn    (memWrEn),
		.wrLaneN (wrOut.laneN),
		.wrData  (wrOut.data),
		.rdData  (memRdata)
	);

	gatedHold_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clock_gate_n |=> $stable(dataOutQ) && $stable(driveQ) && $stable(s2Q)
			&& $stable(beatQ) && $stable(burstQ))
		else $error("Gated edge changed device state");

	selectDecode_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && (select_first_n || select_third_n || !select_second)
			|=> !s1Q.valid && burstQ == BST_IDLE)
		else $error("Load taken while an enable was false");

	readLatency_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && s1Q.valid && !s1Q.write ##1 !en ##1 en |=> driveQ)
		else $error("Read word not driven after two enabled edges");

	backToBack_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && selected && readNotWrite ##1 en && loadCycle && selected
			|=> s1Q.valid && s2Q.valid && !s2Q.write)
		else $error("Consecutive load dropped");

	burstWrap_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load && beatQ == BEAT_TOP |=> beatQ == BEAT_RST
			&& s1Q.addr[BEAT_W-1:0] == baseQ[BEAT_W-1:0])
		else $error("Burst counter did not wrap to start");

	burstDir_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load && burstQ != BST_IDLE
			|=> s1Q.valid && s1Q.write == ($past(burstQ) == BST_WRITE))
		else $error("Burst direction changed during continuation");

	linearOrder_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load && !burst_order_select
			|=> s1Q.addr[BEAT_W-1:0] == BEAT_W'($past(baseQ[BEAT_W-1:0]) + $past(beatQ) + BEAT_ONE))
		else $error("Linear burst address wrong");

	interOrder_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load && burst_order_select
			|=> s1Q.addr[BEAT_W-1:0] == ($past(baseQ[BEAT_W-1:0]) ^ beatQ))
		else $error("Interleaved burst address wrong");

	deselFloat_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && !selected ##1 en ##1 en |=> !driveQ)
		else $error("Bus still driven two cycles after deselect");

	readSurvives_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && selected && readNotWrite ##1 en && loadCycle && !selected
			##1 en |=> driveQ)
		else $error("Deselect cancelled a pending read");

	writeSurvives_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && selected && !readNotWrite ##1 en && loadCycle && !selected
			##1 en |-> wrPushValid && wrPush.addr == $past(addr, 2))
		else $error("Deselect cancelled a pending write");

	outEnable_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		outEnableN || !driveQ |-> !dataOe)
		else $error("Bus driven without output enable or read");

	powerUpFloat_a: assert property (
		@(posedge mclk)
		!rst_n |=> !dataOe && !driveQ)
		else $error("Bus driven after reset");

	laneCarry_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && loadCycle && selected && !readNotWrite ##1 en ##1 en
			|-> wrPushValid && wrPush.laneN == $past(byte_lane_write_n, 2))
		else $error("Write lanes not carried from address cycle");

	gatedPipe_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clock_gate_n |=> $stable(s1Q) && $stable(baseQ) && $stable(memRdata))
		else $error("Gated edge moved the front of the pipeline");

	noopEmpty_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load && burstQ == BST_IDLE |=> !s1Q.valid)
		else $error("Advance without a burst issued an access");

	burstStep_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && advance_or_load |=> beatQ == BEAT_W'($past(beatQ) + BEAT_ONE))
		else $error("Burst counter did not advance");

	outHold_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		en && !(s2Q.valid && !s2Q.write) |=> $stable(dataOutQ))
		else $error("Read word changed without a read slot");

endmodule // pbs_sram_core

// ==== bench/pbs_ctrl_model.sv ====
// Controller model: write words reach the bus two enabled edges after their beat
`timescale 1ns/1ns
module pbs_ctrl_model (
	input  wire logic               mclk,         // Clock
	input  wire logic               clock_gate_n, // High holds the pipe
	input  wire logic               isWr,         // Cycle carries a write beat
	input  wire pbs_pkg::pbs_data_t wd,           // Word for that beat
	output pbs_pkg::pbs_data_t      dataIn        // Driven write data
);
	import pbs_pkg::*;
	logic      wr1Q = 1'b0;
	logic      wr2Q = 1'b0;
	pbs_data_t d1Q  = DATA_RST;
	pbs_data_t d2Q  = DATA_RST;
	// Gated edges push the data slot later
	always @(posedge mclk)
		if (!clock_gate_n)
		begin
			{wr1Q, d1Q} <= {isWr, wd};
			{wr2Q, d2Q} <= {wr1Q, d1Q};
		end
	// Idle slot shows the inverse, never a stale word
	assign dataIn = wr2Q ? d2Q : ~d2Q;
endmodule // pbs_ctrl_model

// ==== bench/tb.sv ====
// Testbench of the pipelined burst SRAM core
`timescale 1ns/1ns
module tb;
	import pbs_pkg::*;
	logic      mclk, rst_n, gateN, adv, rnw, s1n, s2, s3n, bos, oeN, isWr, dataOe, wqr;
	pbs_addr_t addr;
	pbs_lane_t lanes;
	pbs_data_t wd, dataIn, dataOut;
	pbs_data_t mir [pbs_addr_t];
	int        err_count = 0;
	int        n_tests = 0;

	pbs_sram_core DUT (.mclk(mclk), .rst_n(rst_n), .clock_gate_n(gateN), .addr(addr),
		.readNotWrite(rnw), .advance_or_load(adv), .select_first_n(s1n),
		.select_second(s2), .select_third_n(s3n), .byte_lane_write_n(lanes),
		.burst_order_select(bos), .outEnableN(oeN), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .writeQueueReady(wqr));
	pbs_ctrl_model ctrl (.mclk(mclk), .clock_gate_n(gateN), .isWr(isWr), .wd(wd),
		.dataIn(dataIn));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input pbs_data_t exp, input pbs_data_t got);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One command cycle; enables are {first_n, second, third_n}
	task automatic cyc(input logic g, input logic ad, input logic rw, input logic [2:0] en,
		input pbs_addr_t a, input logic w, input pbs_data_t d);
		@(posedge mclk);
		#1;
		{gateN, adv, rnw, s1n, s2, s3n, addr, isWr, wd} = {g, ad, rw, en, a, w, d};
	endtask

	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 1'b1, 3'b110, ADDR_RST, 1'b0, DATA_RST);
	endtask

	function automatic void put(input pbs_addr_t a, input pbs_data_t d);
		pbs_data_t o;
		o = mir.exists(a) ? mir[a] : DATA_RST;
		for (int i = 0; i < LANES; i++)
			if (!lanes[i])
				o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
		mir[a] = o;
	endfunction

	function automatic pbs_addr_t bAddr(input pbs_addr_t a, input int k);
		pbs_beat_t b;
		b = bos ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
		return {a[ADDR_W-1:2], b};
	endfunction

	// Single write, then a deselect that must not drop it
	task automatic wr1(input pbs_addr_t a, input pbs_data_t d);
		cyc(1'b0, 1'b0, 1'b0, 3'b010, a, 1'b1, d);
		put(a, d);
		idle(1);
	endtask

	// Back-to-back reads across gated edges, then output enable
	task automatic gated(input pbs_addr_t a, input pbs_addr_t b);
		cyc(1'b0, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
		cyc(1'b0, 1'b0, 1'b1, 3'b010, b, 1'b0, DATA_RST);
		cyc(1'b1, 1'b0, 1'b0, 3'b010, b, 1'b0, DATA_RST);
		idle(1);
		chk("oe gated", 1'b0, dataOe);
		cyc(1'b1, 1'b0, 1'b0, 3'b010, b, 1'b0, DATA_RST);
		chk("rd a", mir[a], dataOut);
		cyc(1'b1, 1'b1, 1'b0, 3'b001, a, 1'b0, DATA_RST);
		chk("hold a", mir[a], dataOut);
		idle(1);
		chk("hold oe", 1'b1, dataOe);
		idle(1);
		chk("rd b", mir[b], dataOut);
		oeN = 1'b1;
		#1;
		chk("oe off", 1'b0, dataOe);
		idle(1);
		oeN = 1'b0;
	endtask

	// Read then each kind of deselect
	task automatic desel(input pbs_addr_t a);
		logic [2:0] v [3] = '{3'b110, 3'b000, 3'b011};
		foreach (v[i])
		begin
			cyc(1'b0, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
			cyc(1'b0, 1'b0, 1'b1, v[i], a, 1'b0, DATA_RST);
			cyc(1'b0, 1'b1, 1'b1, 3'b010, a, 1'b0, DATA_RST);
			idle(1);
			chk("rd kept oe", 1'b1, dataOe);
			chk("rd kept", mir[a], dataOut);
			idle(1);
			chk("float", 1'b0, dataOe);
			idle(1);
			chk("noop float", 1'b0, dataOe);
		end
	endtask

	// Write whose data slot is pushed out by gated edges, then read back
	task automatic wrGated(input pbs_addr_t a, input pbs_data_t d);
		cyc(1'b0, 1'b0, 1'b0, 3'b010, a, 1'b1, d);
		put(a, d);
		cyc(1'b1, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
		cyc(1'b1, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
		idle(6);
		cyc(1'b0, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
		idle(3);
		chk("gated wr", mir[a], dataOut);
	endtask

	// Five-beat write burst then five-beat read burst
	task automatic burst(input logic order, input pbs_addr_t a);
		pbs_data_t d;
		bos = order;
		for (int k = 0; k < 5; k++)
		begin
			d = {k[3:0], a, 15'h1_234};
			cyc(1'b0, k != 0, k[0], 3'b010, a, 1'b1, d);
			put(bAddr(a, k), d);
		end
		chk("wq ready", 1'b1, wqr);
		idle(6);
		cyc(1'b0, 1'b0, 1'b1, 3'b010, a, 1'b0, DATA_RST);
		repeat (2) cyc(1'b0, 1'b1, 1'b0, 3'b110, a, 1'b0, DATA_RST);
		for (int k = 0; k < 5; k++)
		begin
			cyc(1'b0, k < 2, 1'b0, 3'b110, a, 1'b0, DATA_RST);
			chk("burst rd", mir[bAddr(a, k)], dataOut);
		end
		idle(1);
		chk("burst end", 1'b0, dataOe);
	endtask

	initial
	begin
		{gateN, adv, rnw, s1n, s2, s3n, bos, oeN, isWr} = 9'b0_0111_0000;
		addr = ADDR_RST;
		lanes = LANE_OFF;
		wd = DATA_RST;
		rst_n = 1'b0;
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		idle(1);
		chk("oe power-up", 1'b0, dataOe);
		chk("out power-up", DATA_RST, dataOut);
		chk("wq ready", 1'b1, wqr);
		lanes = 4'h0;
		wr1(17'h0_0100, 36'h1_2345_6789);
		wr1(17'h0_0101, 36'hF_EDCB_A987);
		lanes = 4'hA;
		wr1(17'h0_0100, 36'hA_BBBB_CCCC);
		lanes = 4'h0;
		idle(6);
		gated(17'h0_0100, 17'h0_0101);
		desel(17'h0_0101);
		wrGated(17'h0_0102, 36'h5_A5A5_5A5A);
		burst(1'b0, 17'h0_0206);
		burst(1'b1, 17'h0_0305);
		close_out();
	end

	initial
	begin
		#40000;
		err_count++;
		close_out();
	end
endmodule // tb
